/* rtl/cmc_map.vh */
`ifndef CMC_MAP_VH
`define CMC_MAP_VH
// ==========================================
// register byte offsets
`define CMC_SYS_OFS 6'h00
`define CMC_OSC_OFS 6'h04
`define CMC_STB_OFS 6'h08
`define CMC_PLL_OFS 6'h0C
`define CMC_GTA_OFS 6'h20
`define CMC_GTB_OFS 6'h24
`define CMC_KEY_OFS 6'h3C
`define CMC_CTL_OFS 6'h30
// ==========================================
// writable masks and reset values
`define CMC_SYS_MASK 32'h0013_1707
`define CMC_SYS_RST 32'h0001_0000
`define CMC_OSC_MASK 32'hFFFF_058B
`define CMC_OSC_RST 32'h8000_000A
`define CMC_STB_MASK 32'h0002_0007
`define CMC_STB_RST 32'h0000_0003
`define CMC_PLL_MASK 32'h0003_FFFE
`define CMC_PLL_RST 32'h0000_0000
`define CMC_GTA_MASK 32'hF81F_E7FF
`define CMC_GTB_MASK 32'hF7FE_7C0F
`define CMC_KEY_OPEN 8'hC1
`define CMC_CTL_MASK 32'h0000_0001
// stop-mode return restores these bits
`define CMC_OSC_WAKE_MASK 32'h0003_0103
`define CMC_PLL_WAKE_MASK 32'h0003_0000
// ==========================================
// field positions
`define CMC_ADC_STOP 20
`define CMC_CKO_HI 17
`define CMC_CKO_LO 16
`define CMC_PSRC 12
`define CMC_PRE_HI 10
`define CMC_PRE_LO 8
`define CMC_GEAR_HI 2
`define CMC_GEAR_LO 0
`define CMC_WUP_HI 31
`define CMC_WUP_LO 20
`define CMC_WUPL_HI 19
`define CMC_WUPL_LO 18
`define CMC_WOSC 17
`define CMC_WSPD 16
`define CMC_WFLAG 15
`define CMC_WSTART 14
`define CMC_EXT_TYPE 10
`define CMC_OSC_USE 9
`define CMC_OSC_SEL 8
`define CMC_DRIVE 7
`define CMC_SLOW_EN 3
`define CMC_IFAST_EN 1
`define CMC_EFAST_USE 0
`define CMC_HOLD 17
`define CMC_MODE_HI 2
`define CMC_MODE_LO 0
`define CMC_MUL_USE 18
`define CMC_MUL_SEL 17
`define CMC_MUL_EN 16
`define CMC_WAKE 0
`define CMC_SET_HI 15
`define CMC_SET_LO 1
`define CMC_KEY_HI 7
`define CMC_KEY_LO 0
// ==========================================
// codes and constants
`define CMC_MODE_HALT1 3'h1
`define CMC_MODE_IDLE 3'h3
`define CMC_MODE_HALT2 3'h5
`define CMC_SWITCH_CYC 4'h8
`define CMC_CNT_W 16
`define CMC_DIV_W 6
`endif

/* rtl/cmc_divider.v */
`timescale 1ns/1ps
// ==========================================
// free-running divider; tap k is clk/2^(k+1)
module cmc_divider (
    input wire clk_i,
    input wire rst_i,
    output reg [5:0] tap_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            tap_o <= 6'h00;
        end else begin
            tap_o <= tap_o + 6'h01;
        end
    end
endmodule

/* rtl/cmc_top.v */
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cmc_map.vh"
// What this block does
// R01: converter clock stop bit gates its clock
// R02: clock output select routes four sources
// R03: peripheral source: geared or undivided clock
// R04: prescaler divides peripheral clock by 1..32
// R05: gear divides fast clock by 1..16
// R06: warm-up counter high twelve bits loaded
// R07: low two bits used when counting slow
// R08: warm-up clock chosen by two bits; the counter here always counts cnt_tick_i
// R09: warm-up flag reads one while counting
// R10: warm-up start write-one, reads zero
// R11: software sets source type before select
// R12: oscillator select with in-use status
// R13: slow external oscillator enable, resets one
// R14: internal fast enable, external fast used
// R15: stop-mode return restores selected bits
// R16: slow oscillator drive bit, resets zero
// R17: port hold freezes I/O on rising set
// R18: standby mode field, resets to idle
// R19: multiplier select with in-use status
// R20: multiplier enable, resets zero
// R21: software loads only listed multiplier codes
// R22: gate bits stop peripheral clocks when one
// R23: protect key 0xC1 enables other writes
// R24: software sets gate only after stop
// R25: reserved bits ignore writes, read zero
// R26: source switches settle before status updates
module cmc_top (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire stop_wake_i,
    input wire cnt_tick_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg adc_clk_en_o,
    output reg clock_out_pin_o,
    output reg [5:0] pclk_div_o,
    output reg [4:0] gear_div_o,
    output reg pclk_from_fast_o,
    output reg ifast_osc_run_o,
    output reg efast_used_o,
    output reg slow_osc_run_o,
    output reg slow_osc_drive_o,
    output reg ext_crystal_o,
    output reg fast_src_ext_o,
    output reg mul_run_o,
    output reg mul_src_o,
    output reg [14:0] mul_setting_o,
    output reg port_hold_o,
    output reg [2:0] standby_mode_o,
    output reg [31:0] gate_a_o,
    output reg [31:0] gate_b_o
);
    // ==========================================
    // registers
    reg [31:0] sys_q;
    reg [31:0] osc_q;
    reg [31:0] stb_q;
    reg [31:0] pll_q;
    reg [31:0] gta_q;
    reg [31:0] gtb_q;
    reg [7:0] key_q;
    reg [31:0] ctl_q;
    reg osc_use_q;
    reg mul_use_q;
    reg [3:0] osc_cnt_q;
    reg [3:0] mul_cnt_q;
    reg [15:0] wup_cnt_q;
    reg wup_run_q;
    reg hold_prev_q;
    reg wake_s1_q;
    reg wake_s2_q;
    reg wake_s3_q;
    reg tick_s1_q;
    reg tick_s2_q;
    wire [5:0] tap;
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // protect key gate
    // R23: key gates writes
    wire open_w = (key_q == `CMC_KEY_OPEN);
    wire wake_ev = wake_s2_q & ~wake_s3_q;

    cmc_divider u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tap_o(tap)
    );

    function [31:0] merge;
        input [31:0] old;
        input [31:0] wmask;
        input [31:0] data;
        input [31:0] sel;
        begin
            // R25: reserved bits dropped
            merge = (old & ~(wmask & sel)) | (data & wmask & sel);
        end
    endfunction

    // ==========================================
    // input synchronisers
    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            wake_s3_q <= 1'b0;
            tick_s1_q <= 1'b0;
            tick_s2_q <= 1'b0;
        end else begin
            wake_s1_q <= stop_wake_i;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
            tick_s1_q <= cnt_tick_i;
            tick_s2_q <= tick_s1_q;
        end
    end

    // ==========================================
    // register writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            sys_q <= `CMC_SYS_RST;
            osc_q <= `CMC_OSC_RST;
            stb_q <= `CMC_STB_RST;
            pll_q <= `CMC_PLL_RST;
            gta_q <= 32'h0000_0000;
            gtb_q <= 32'h0000_0000;
            key_q <= `CMC_KEY_OPEN;
            ctl_q <= 32'h0000_0000;
        end else begin
            if (wr && wb_adr_i == `CMC_KEY_OFS && wb_sel_i[0]) begin
                key_q <= wb_dat_i[`CMC_KEY_HI:`CMC_KEY_LO];
            end
            if (wr && open_w) begin
                case (wb_adr_i)
                    `CMC_SYS_OFS: begin
                        sys_q <= merge(sys_q, `CMC_SYS_MASK, wb_dat_i, bmask);
                    end
                    `CMC_STB_OFS: begin
                        // R18: mode field stored
                        stb_q <= merge(stb_q, `CMC_STB_MASK, wb_dat_i, bmask);
                    end
                    `CMC_GTA_OFS: begin
                        // R22: gate bits stored
                        gta_q <= merge(gta_q, `CMC_GTA_MASK, wb_dat_i, bmask);
                    end
                    `CMC_GTB_OFS: begin
                        gtb_q <= merge(gtb_q, `CMC_GTB_MASK, wb_dat_i, bmask);
                    end
                    `CMC_CTL_OFS: begin
                        ctl_q <= merge(ctl_q, `CMC_CTL_MASK, wb_dat_i, bmask);
                    end
                    default: begin
                    end
                endcase
            end
            // R15: stop return restore
            if (wake_ev) begin
                osc_q <= (osc_q & ~`CMC_OSC_WAKE_MASK) | (`CMC_OSC_RST & `CMC_OSC_WAKE_MASK);
                pll_q <= (pll_q & ~`CMC_PLL_WAKE_MASK) | (`CMC_PLL_RST & `CMC_PLL_WAKE_MASK);
            end else if (wr && open_w && wb_adr_i == `CMC_OSC_OFS) begin
                // R12: select stored; R13 R14 R16 enables stored
                osc_q <= merge(osc_q, `CMC_OSC_MASK, wb_dat_i, bmask);
            end else if (wr && open_w && wb_adr_i == `CMC_PLL_OFS) begin
                // R20: enable stored; R21 setting stored
                pll_q <= merge(pll_q, `CMC_PLL_MASK, wb_dat_i, bmask);
            end
        end
    end

    // ==========================================
    // glitch-free source switch status
    always @(posedge clk_i) begin
        if (rst_i) begin
            osc_use_q <= 1'b0;
            mul_use_q <= 1'b0;
            osc_cnt_q <= 4'h0;
            mul_cnt_q <= 4'h0;
        end else begin
            // R26: settle before status; R12 status follows request
            if (osc_use_q == osc_q[`CMC_OSC_SEL]) begin
                osc_cnt_q <= 4'h0;
            end else if (osc_cnt_q == `CMC_SWITCH_CYC) begin
                osc_use_q <= osc_q[`CMC_OSC_SEL];
                osc_cnt_q <= 4'h0;
            end else begin
                osc_cnt_q <= osc_cnt_q + 4'h1;
            end
            // R19: multiplier status follows request
            if (mul_use_q == pll_q[`CMC_MUL_SEL]) begin
                mul_cnt_q <= 4'h0;
            end else if (mul_cnt_q == `CMC_SWITCH_CYC) begin
                mul_use_q <= pll_q[`CMC_MUL_SEL];
                mul_cnt_q <= 4'h0;
            end else begin
                mul_cnt_q <= mul_cnt_q + 4'h1;
            end
        end
    end

    // ==========================================
    // warm-up counter
    wire wup_go = wr && open_w && wb_adr_i == `CMC_OSC_OFS && wb_sel_i[1]
                  && wb_dat_i[`CMC_WSTART];
    wire slow_cnt = osc_q[`CMC_WSPD];
    always @(posedge clk_i) begin
        if (rst_i) begin
            wup_cnt_q <= 16'h0000;
            wup_run_q <= 1'b0;
        end else if (wup_go) begin
            // R10: start on write one
            // R06: high part; R07 low part when slow
            wup_run_q <= 1'b1;
            wup_cnt_q <= {osc_q[`CMC_WUP_HI:`CMC_WUP_LO],
                          (slow_cnt ? osc_q[`CMC_WUPL_HI:`CMC_WUPL_LO] : 2'b00), 2'b00};
        end else if (wup_run_q && tick_s2_q) begin
            // R08: counts synchronised cnt_tick_i tick
            if (wup_cnt_q == 16'h0000) begin
                wup_run_q <= 1'b0;
            end else begin
                wup_cnt_q <= wup_cnt_q - 16'h0001;
            end
        end
    end

    // ==========================================
    // bus read and ack
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        case (wb_adr_i)
            `CMC_SYS_OFS: rd_d = sys_q;
            `CMC_OSC_OFS: begin
                // R09: flag; R10 start reads zero
                rd_d = osc_q & ~(32'h1 << `CMC_WSTART);
                rd_d[`CMC_WFLAG] = wup_run_q;
                rd_d[`CMC_OSC_USE] = osc_use_q;
            end
            `CMC_STB_OFS: rd_d = stb_q;
            `CMC_PLL_OFS: begin
                rd_d = pll_q;
                rd_d[`CMC_MUL_USE] = mul_use_q;
            end
            `CMC_GTA_OFS: rd_d = gta_q;
            `CMC_GTB_OFS: rd_d = gtb_q;
            `CMC_KEY_OFS: rd_d = {24'h000000, key_q};
            `CMC_CTL_OFS: rd_d = ctl_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_d : 32'h0000_0000;
        end
    end

    // ==========================================
    // clock control outputs
    wire [1:0] cko = sys_q[`CMC_CKO_HI:`CMC_CKO_LO];
    wire [2:0] gear = sys_q[`CMC_GEAR_HI:`CMC_GEAR_LO];
    wire [2:0] pre = sys_q[`CMC_PRE_HI:`CMC_PRE_LO];
    reg cko_d;
    reg [4:0] gear_d;
    reg [5:0] pre_d;
    always @* begin
        // R02: clock output routing
        case (cko)
            2'h0: cko_d = tick_s2_q;
            2'h1: cko_d = tap[2];
            2'h2: cko_d = tap[1];
            2'h3: cko_d = tap[0];
            default: cko_d = 1'b0;
        endcase
        // R05: gear one-hot divide
        case (gear)
            3'h4: gear_d = 5'h02;
            3'h5: gear_d = 5'h04;
            3'h6: gear_d = 5'h08;
            3'h7: gear_d = 5'h10;
            default: gear_d = 5'h01;
        endcase
        // R04: prescaler one-hot divide
        case (pre)
            3'h0: pre_d = 6'h01;
            3'h1: pre_d = 6'h02;
            3'h2: pre_d = 6'h04;
            3'h3: pre_d = 6'h08;
            3'h4: pre_d = 6'h10;
            3'h5: pre_d = 6'h20;
            default: pre_d = 6'h01;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            adc_clk_en_o <= 1'b1;
            clock_out_pin_o <= 1'b0;
            pclk_div_o <= 6'h01;
            gear_div_o <= 5'h01;
            pclk_from_fast_o <= 1'b0;
            ifast_osc_run_o <= 1'b1;
            efast_used_o <= 1'b0;
            slow_osc_run_o <= 1'b1;
            slow_osc_drive_o <= 1'b0;
            ext_crystal_o <= 1'b0;
            fast_src_ext_o <= 1'b0;
            mul_run_o <= 1'b0;
            mul_src_o <= 1'b0;
            mul_setting_o <= 15'h0000;
            port_hold_o <= 1'b0;
            hold_prev_q <= 1'b0;
            standby_mode_o <= `CMC_MODE_IDLE;
            gate_a_o <= 32'h0000_0000;
            gate_b_o <= 32'h0000_0000;
        end else begin
            // R01: converter clock gate
            adc_clk_en_o <= ~sys_q[`CMC_ADC_STOP];
            clock_out_pin_o <= cko_d;
            pclk_div_o <= pre_d;
            gear_div_o <= gear_d;
            // R03: peripheral source select
            pclk_from_fast_o <= sys_q[`CMC_PSRC];
            // R14: fast oscillator controls
            ifast_osc_run_o <= osc_q[`CMC_IFAST_EN];
            efast_used_o <= osc_q[`CMC_EFAST_USE];
            // R13: slow oscillator run
            slow_osc_run_o <= osc_q[`CMC_SLOW_EN];
            // R16: slow drive
            slow_osc_drive_o <= osc_q[`CMC_DRIVE];
            ext_crystal_o <= osc_q[`CMC_EXT_TYPE];
            fast_src_ext_o <= osc_use_q;
            // R20: multiplier run
            mul_run_o <= pll_q[`CMC_MUL_EN];
            mul_src_o <= mul_use_q;
            mul_setting_o <= pll_q[`CMC_SET_HI:`CMC_SET_LO];
            // R17: hold on rising set
            hold_prev_q <= stb_q[`CMC_HOLD];
            if (!stb_q[`CMC_HOLD]) begin
                port_hold_o <= 1'b0;
            end else if (!hold_prev_q && stb_q[`CMC_MODE_HI:`CMC_MODE_LO] == `CMC_MODE_HALT2) begin
                port_hold_o <= 1'b1;
            end else if (!hold_prev_q) begin
                port_hold_o <= 1'b1;
            end
            standby_mode_o <= stb_q[`CMC_MODE_HI:`CMC_MODE_LO];
            gate_a_o <= gta_q;
            gate_b_o <= gtb_q;
        end
    end
endmodule

/* test/cmc_assertions.sv */
`timescale 1ns/1ps
`include "cmc_map.vh"
// ==========================================
// port checks on the clock and mode block
module cmc_assertions (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire stop_wake_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire adc_clk_en_o,
    input wire [5:0] pclk_div_o,
    input wire [4:0] gear_div_o,
    input wire mul_src_o,
    input wire [2:0] standby_mode_o,
    input wire [31:0] gate_a_o
);
    wire rd_sys = wb_ack_o && !wb_we_i && wb_adr_i == `CMC_SYS_OFS;
    wire rd_gta = wb_ack_o && !wb_we_i && wb_adr_i == `CMC_GTA_OFS;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("request not answered by one ack pulse");
    a_adc_gate: assert property (rd_sys |-> adc_clk_en_o == !wb_dat_o[20])
        else $error("converter clock enable disagrees with stop bit");
    a_prescale_div: assert property (rd_sys && wb_dat_o[10:8] < 3'h6 |->
        pclk_div_o == 6'h01 << wb_dat_o[10:8]) else $error("prescaler divide wrong");
    a_gear_div: assert property (rd_sys && wb_dat_o[2] |->
        gear_div_o == 5'h02 << wb_dat_o[1:0]) else $error("gear divide wrong");
    a_reserved_zero: assert property (rd_sys |-> (wb_dat_o & ~`CMC_SYS_MASK) == 32'h0)
        else $error("reserved system bits read nonzero");
    a_gate_mirror: assert property (rd_gta |-> wb_dat_o[26:21] == 6'h00 &&
        wb_dat_o[31:27] == gate_a_o[31:27]) else $error("gate outputs disagree");
    a_reset_vals: assert property ($fell(rst_i) |->
        standby_mode_o == `CMC_MODE_IDLE && adc_clk_en_o) else $error("reset values wrong");
    a_wake_clear: assert property ($rose(stop_wake_i) |-> ##[3:16] !mul_src_o)
        else $error("multiplier source not restored on wake");
endmodule

bind cmc_top cmc_assertions cmc_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .stop_wake_i(stop_wake_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .adc_clk_en_o(adc_clk_en_o), .pclk_div_o(pclk_div_o), .gear_div_o(gear_div_o),
    .mul_src_o(mul_src_o), .standby_mode_o(standby_mode_o), .gate_a_o(gate_a_o));

/* test/cmc_top_tb.sv */
`timescale 1ns/1ps
module cmc_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic stop_wake_i = 1'b0;
    logic cnt_tick_i = 1'b0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, adc_clk_en_o, ck_o, pfast, fsrc, mrun, msrc, hold, ifast, slow, efast, drive, ext;
    wire [5:0] pclk_div_o;
    wire [4:0] gear_div_o;
    wire [14:0] mset;
    wire [2:0] mode;
    wire [31:0] gate_a_o, gate_b_o;
    logic [31:0] rd;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    always #2.5 clk_i = ~clk_i;
    cmc_top cmc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .stop_wake_i(stop_wake_i), .cnt_tick_i(cnt_tick_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .adc_clk_en_o(adc_clk_en_o), .clock_out_pin_o(ck_o),
        .pclk_div_o(pclk_div_o), .gear_div_o(gear_div_o), .pclk_from_fast_o(pfast),
        .ifast_osc_run_o(ifast), .efast_used_o(efast), .slow_osc_run_o(slow),
        .slow_osc_drive_o(drive), .ext_crystal_o(ext), .fast_src_ext_o(fsrc), .mul_run_o(mrun),
        .mul_src_o(msrc), .mul_setting_o(mset), .port_hold_o(hold),
        .standby_mode_o(mode), .gate_a_o(gate_a_o), .gate_b_o(gate_b_o));
    // ==========================================
    // shared tasks
    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic tick(input int n);
        @(posedge clk_i);
        cnt_tick_i <= 1'b1;
        idle(n);
        cnt_tick_i <= 1'b0;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset;
        logic [5:0] a [8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h20, 6'h24, 6'h3C, 6'h10};
        logic [31:0] e [8] = '{32'h10000, 32'h8000000A, 32'h3, 0, 0, 0, 32'hC1, 0};
        for (int i = 0; i < 8; i++) begin
            bus(0, a[i], 0);
            chk(rd, e[i]);
        end
        chk({ifast, slow, efast, drive, ext, pclk_div_o, gear_div_o}, {2'h3, 3'h0, 6'h01, 5'h01});
    endtask
    task automatic t_sys;
        logic [2:0] g;
        logic p;
        int n;
        for (int i = 0; i < 6; i++) begin
            g = (i % 5 == 0) ? 3'h0 : 3'(3 + i);
            bus(1, 6'h00, {21'h0, i[2:0], 5'h0, g});
            idle(2);
            chk(pclk_div_o, 6'h01 << i);
            chk(gear_div_o, 5'h01 << (i % 5));
        end
        bus(1, 6'h00, 32'hFFFF_FDFD);
        bus(0, 6'h00, 0);
        chk(rd, 32'h0013_1505);
        chk({adc_clk_en_o, pfast}, 2'h1);
        for (int k = 0; k < 4; k++) begin
            bus(1, 6'h00, {14'h0, k[1:0], 16'h0});
            n = 0;
            idle(3);
            cnt_tick_i <= 1'b1;
            repeat (32) begin
                p = ck_o;
                @(posedge clk_i);
                n += int'(ck_o && !p);
            end
            cnt_tick_i <= 1'b0;
            chk(n, k == 0 ? 1 : 2 << k);
        end
    endtask
    task automatic t_osc;
        logic [31:0] d [3] = '{32'h0010_0000, 32'h000D_0000, 32'h000C_0000};
        bus(1, 6'h04, 32'h0000_040A);
        bus(1, 6'h04, 32'h0000_050A);
        bus(0, 6'h04, 0);
        chk({rd, fsrc}, {32'h0000_050A, 1'b0});
        idle(10);
        bus(0, 6'h04, 0);
        chk({rd, fsrc}, {32'h0000_070A, 1'b1});
        for (int i = 0; i < 3; i++) begin
            bus(1, 6'h04, d[i] | 32'h0000_050A);
            bus(1, 6'h04, d[i] | 32'h0000_450A);
            bus(0, 6'h04, 0);
            chk(rd, d[i] | 32'h0000_870A);
            tick(6);
            bus(0, 6'h04, 0);
            chk(rd[15], i < 2);
            tick(25);
            bus(0, 6'h04, 0);
            chk(rd[15], 1'b0);
        end
    endtask
    task automatic t_mul_wake;
        bus(1, 6'h0C, {14'h0, 2'h3, 15'h692E, 1'b1});
        bus(0, 6'h0C, 0);
        chk({rd, mrun, msrc}, {14'h0, 2'h3, 15'h692E, 1'b0, 2'h2});
        idle(10);
        bus(0, 6'h0C, 0);
        chk({rd[18], msrc, mset}, {2'h3, 15'h692E});
        bus(1, 6'h04, 32'h0003_0589);
        idle(12);
        chk({efast, ext, drive}, 3'h7);
        stop_wake_i <= 1'b1;
        idle(4);
        stop_wake_i <= 1'b0;
        idle(16);
        bus(0, 6'h04, 0);
        chk({rd, ifast, efast}, {32'h0000_048A, 2'h2});
        bus(0, 6'h0C, 0);
        chk(rd, 32'h0000_D25C);
    endtask
    task automatic t_standby_mode_select_gate;
        logic [2:0] m [3] = '{3'h1, 3'h3, 3'h5};
        for (int i = 0; i < 3; i++) begin
            bus(1, 6'h08, 32'hFFFF_FFF8 | m[i]);
            bus(0, 6'h08, 0);
            chk({rd, mode, hold}, {32'h0002_0000 | m[i], m[i], 1'b1});
        end
        bus(1, 6'h08, 32'h3);
        idle(2);
        chk(hold, 1'b0);
        bus(1, 6'h20, 32'hFFFF_FFFF);
        bus(1, 6'h24, 32'hFFFF_FFFF);
        bus(0, 6'h20, 0);
        chk({rd, gate_a_o}, {2{32'hF81F_E7FF}});
        bus(0, 6'h24, 0);
        chk({rd, gate_b_o}, {2{32'hF7FE_7C0F}});
    endtask
    task automatic t_key;
        bus(1, 6'h3C, 32'h0);
        bus(1, 6'h00, 32'h0);
        bus(0, 6'h00, 0);
        chk(rd, 32'h0003_0000);
        bus(0, 6'h3C, 0);
        chk(rd, 32'h0);
        bus(1, 6'h3C, 32'hC1);
        bus(1, 6'h10, 32'hFFFF_FFFF);
        bus(1, 6'h00, 32'h0001_0000);
        bus(0, 6'h00, 0);
        chk(rd, 32'h0001_0000);
        bus(0, 6'h10, 0);
        chk(rd, 32'h0);
        bus(1, 6'h30, 32'hFFFF_FFFF);
        bus(0, 6'h30, 0);
        chk(rd, 32'h1);
    endtask
    // ==========================================
    // run control
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_sys();
        t_osc();
        t_mul_wake();
        t_standby_mode_select_gate();
        t_key();
        results();
    end
endmodule
